// ===== timer_capture_pkg.sv
// Package: register map, field positions, reset values and state types of the capture timer
package timer_capture_pkg;

  // Register byte offsets
  localparam logic [5:0] CONTROL_REG_A_OFS = 6'h00;
  localparam logic [5:0] CONTROL_REG_B_OFS = 6'h04;
  localparam logic [5:0] TIMER_COUNT_OFS = 6'h08;
  localparam logic [5:0] CAPTURE_REGISTER_OFS = 6'h0c;
  localparam logic [5:0] SECOND_COMPARE_OFS = 6'h10;
  localparam logic [5:0] STATUS_OFS = 6'h14;

  // Field positions in control_reg_a
  localparam int RUN_BIT_POS = 0;
  localparam int CLK_SRC_POS = 1;
  localparam int EDGE_POLARITY_LOW_POS = 3;
  localparam int EDGE_POLARITY_HIGH_POS = 4;
  localparam int TRIGGER_SOURCE_BIT_POS = 7;
  // Field positions in control_reg_b
  localparam int FILTER_RATE_LOW_POS = 0;
  localparam int FILTER_RATE_HIGH_POS = 1;
  localparam int COMPARE_MODE_POS = 3;
  localparam int PIN_GPIO_POS = 4;

  // Count source, polarity and filter encodings
  localparam logic [1:0] SRC_UNDIVIDED = 2'h0;
  localparam logic [1:0] SRC_DIV8 = 2'h1;
  localparam logic [1:0] SRC_DIV32 = 2'h2;
  localparam logic [1:0] SRC_FAST_OSC = 2'h3;
  localparam logic [1:0] POL_RISING = 2'h0;
  localparam logic [1:0] POL_FALLING = 2'h1;
  localparam logic [1:0] POL_BOTH = 2'h2;
  localparam logic [1:0] FILT_OFF = 2'h0;
  localparam logic [1:0] FILT_UNDIVIDED = 2'h1;
  localparam logic [1:0] FILT_DIV8 = 2'h2;
  localparam logic [1:0] FILT_DIV32 = 2'h3;

  // Prescaler terminal counts for the divide-by-8 and divide-by-32 ticks; counter maximum and reset value
  localparam logic [2:0] DIV8_LAST = 3'h7;
  localparam logic [4:0] DIV32_LAST = 5'h1f;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // Consecutive equal samples the noise filter needs
  localparam int FILTER_TAPS = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Whole state of the timer core and its bus slave
  typedef struct packed {
    logic run;
    logic [1:0] clk_src;
    logic [1:0] polarity;
    logic trig_src;
    logic [1:0] filt_rate;
    logic compare_mode;
    logic pin_gpio;
    logic [15:0] count;
    logic [15:0] capture;
    logic [15:0] compare1;
    logic [4:0] presc;
    logic pin_meta;
    logic pin_sync;
    logic fast_meta;
    logic fast_sync;
    logic fast_prev;
    logic slow_meta;
    logic slow_sync;
    logic trig_prev;
    logic edge_irq;
    logic ovf_irq;
    logic cmp_irq;
    logic aw_got;
    logic [5:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } timer_state_t;

  localparam timer_state_t TIMER_STATE_RESET = '0;

  // State of the pin noise filter
  typedef struct packed {
    logic [FILTER_TAPS-1:0] samples;
    logic level;
  } filter_state_t;

  localparam filter_state_t FILTER_STATE_RESET = '0;

endpackage : timer_capture_pkg

// ===== capture_noise_filter.sv
// Digital noise filter: output follows the input only after consecutive equal samples
`timescale 1ns/1ps
module capture_noise_filter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sample_en,
  input wire logic din,
  output logic level
);

  timer_capture_pkg::filter_state_t s;
  timer_capture_pkg::filter_state_t next_s;

  // Shift on each sample strobe; a short glitch never fills the window
  always_comb begin
    next_s = s;
    if (sample_en) begin
      next_s.samples = {s.samples[timer_capture_pkg::FILTER_TAPS-2:0], din};
      if (&next_s.samples) begin
        next_s.level = 1'b1;
      end else if (~|next_s.samples) begin
        next_s.level = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= timer_capture_pkg::FILTER_STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;

endmodule : capture_noise_filter

// ===== timer_input_capture.sv
// Top: 16-bit capture timer with compare match, noise filter and AXI4-Lite registers
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// - Count up once per tick of the undivided, div8, div32 or fast oscillator source.
// - In capture mode each active trigger edge copies the live count into the capture register.
// - Count while the run bit is one; stop when software clears it.
// - Stopping by clearing the run bit forces the count to zero.
// - An active trigger edge pulses the external edge interrupt request.
// - A wrap past the maximum count pulses the overflow interrupt request.
// - Edge interrupt follows filter delay plus at most one count source period.
// - In capture mode writes to count and capture registers are ignored.
// - Count reads give the live count; capture reads give the last latched value.
// - Two polarity bits choose which trigger edge is active.
// - The pin passes a digital filter whose sample rate two bits select.
// - Trigger source bit picks the filtered pin or the slow oscillator divided clock.
// - The pin is either general purpose I/O or the measured pulse input.
// - Waveform pins stay ordinary I/O while capture mode is selected.
// - In compare mode a count equal to either compare register pulses an interrupt.
// - Source field: 00 undivided, 01 div8, 10 div32, 11 fast oscillator.
// - Polarity field: 00 rising, 01 falling, 10 both; 11 is forbidden.
module timer_input_capture (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [5:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic capture_input_pin,
  input wire logic fast_osc_clock,
  input wire logic slow_osc_div_clock,
  output logic capture_pin_level,
  output logic external_edge_irq,
  output logic overflow_irq,
  output logic compare_irq,
  output logic wave_pins_claimed
);

  timer_capture_pkg::timer_state_t s;
  timer_capture_pkg::timer_state_t next_s;
  logic filt_level;
  logic filt_sample;
  logic tick;
  logic trig_level;
  logic rise;
  logic fall;
  logic trig_edge;
  logic cap_event;
  logic do_write;
  logic wr_capture;
  logic [15:0] next_count;
  logic [31:0] rd_value;
  logic rd_hit;
  logic wr_hit;

  // Byte-lane merge for registers up to 16 bits wide
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16

  ////////////////////////////////////////////////////////////////////////////
  // Tick and trigger decode

  // Count tick selection; fast oscillator is sampled, so it must run well below aclk/2
  always_comb begin
    case (s.clk_src)
      timer_capture_pkg::SRC_UNDIVIDED: tick = 1'b1;
      timer_capture_pkg::SRC_DIV8: tick = (s.presc[2:0] == timer_capture_pkg::DIV8_LAST);
      timer_capture_pkg::SRC_DIV32: tick = (s.presc == timer_capture_pkg::DIV32_LAST);
      timer_capture_pkg::SRC_FAST_OSC: tick = s.fast_sync & ~s.fast_prev;
      default: tick = 1'b0;
    endcase
  end

  // Filter sample strobe from the same prescaler
  always_comb begin
    case (s.filt_rate)
      timer_capture_pkg::FILT_UNDIVIDED: filt_sample = 1'b1;
      timer_capture_pkg::FILT_DIV8: filt_sample = (s.presc[2:0] == timer_capture_pkg::DIV8_LAST);
      timer_capture_pkg::FILT_DIV32: filt_sample = (s.presc == timer_capture_pkg::DIV32_LAST);
      default: filt_sample = 1'b0;
    endcase
  end

  capture_noise_filter u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_en(filt_sample),
    .din(s.pin_sync),
    .level(filt_level)
  );

  // Trigger source and edge polarity; forbidden polarity code never fires
  assign trig_level = s.trig_src ? s.slow_sync :
                      ((s.filt_rate == timer_capture_pkg::FILT_OFF) ? s.pin_sync : filt_level);
  assign rise = trig_level & ~s.trig_prev;
  assign fall = ~trig_level & s.trig_prev;
  always_comb begin
    case (s.polarity)
      timer_capture_pkg::POL_RISING: trig_edge = rise;
      timer_capture_pkg::POL_FALLING: trig_edge = fall;
      timer_capture_pkg::POL_BOTH: trig_edge = rise | fall;
      default: trig_edge = 1'b0;
    endcase
    // A pin left as general purpose I/O triggers nothing
    if (!s.trig_src && s.pin_gpio) begin
      trig_edge = 1'b0;
    end
  end
  assign cap_event = trig_edge & ~s.compare_mode;

  // Next count; stopping clears it so a restart always begins from zero
  always_comb begin
    if (!s.run) begin
      next_count = timer_capture_pkg::COUNT_RESET;
    end else if (tick) begin
      next_count = s.count + 16'h0001;
    end else begin
      next_count = s.count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  assign do_write = s.aw_got & s.w_got & ~s.bvalid;
  assign wr_capture = do_write && (s.awaddr == timer_capture_pkg::CAPTURE_REGISTER_OFS) && s.compare_mode;

  always_comb begin
    rd_value = 32'h0000_0000;
    rd_hit = 1'b1;
    case (araddr)
      timer_capture_pkg::CONTROL_REG_A_OFS: begin
        rd_value[timer_capture_pkg::RUN_BIT_POS] = s.run;
        rd_value[timer_capture_pkg::CLK_SRC_POS+:2] = s.clk_src;
        rd_value[timer_capture_pkg::EDGE_POLARITY_LOW_POS] = s.polarity[0];
        rd_value[timer_capture_pkg::EDGE_POLARITY_HIGH_POS] = s.polarity[1];
        rd_value[timer_capture_pkg::TRIGGER_SOURCE_BIT_POS] = s.trig_src;
      end
      timer_capture_pkg::CONTROL_REG_B_OFS: begin
        rd_value[timer_capture_pkg::FILTER_RATE_LOW_POS] = s.filt_rate[0];
        rd_value[timer_capture_pkg::FILTER_RATE_HIGH_POS] = s.filt_rate[1];
        rd_value[timer_capture_pkg::COMPARE_MODE_POS] = s.compare_mode;
        rd_value[timer_capture_pkg::PIN_GPIO_POS] = s.pin_gpio;
      end
      // Whole-word reads keep the two count bytes coherent
      timer_capture_pkg::TIMER_COUNT_OFS: rd_value[15:0] = s.count;
      timer_capture_pkg::CAPTURE_REGISTER_OFS: rd_value[15:0] = s.capture;
      timer_capture_pkg::SECOND_COMPARE_OFS: rd_value[15:0] = s.compare1;
      timer_capture_pkg::STATUS_OFS: rd_value[1:0] = {s.run, s.pin_sync};
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    case (s.awaddr)
      timer_capture_pkg::CONTROL_REG_A_OFS, timer_capture_pkg::CONTROL_REG_B_OFS,
      timer_capture_pkg::TIMER_COUNT_OFS, timer_capture_pkg::CAPTURE_REGISTER_OFS,
      timer_capture_pkg::SECOND_COMPARE_OFS, timer_capture_pkg::STATUS_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s = s;
    // Two-flop synchronisers for the pin and both oscillators
    next_s.pin_meta = capture_input_pin;
    next_s.pin_sync = s.pin_meta;
    next_s.fast_meta = fast_osc_clock;
    next_s.fast_sync = s.fast_meta;
    next_s.fast_prev = s.fast_sync;
    next_s.slow_meta = slow_osc_div_clock;
    next_s.slow_sync = s.slow_meta;
    next_s.trig_prev = trig_level;
    next_s.presc = s.presc + 5'h01;
    // Counter, overflow and compare match
    next_s.count = next_count;
    next_s.ovf_irq = s.run && tick && (s.count == timer_capture_pkg::COUNT_MAX);
    next_s.cmp_irq = s.run && tick && s.compare_mode &&
                     ((next_count == s.capture) || (next_count == s.compare1));
    // Edge interrupt one cycle after the filtered edge, within one source period
    next_s.edge_irq = trig_edge;
    if (cap_event) begin
      next_s.capture = s.count;
    end
    // Write channel: address and data are taken in either order
    if (do_write) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_hit ? timer_capture_pkg::RESP_OKAY : timer_capture_pkg::RESP_SLVERR;
      // Selections are assumed stable while running
      case (s.awaddr)
        timer_capture_pkg::CONTROL_REG_A_OFS: begin
          if (s.wstrb[0]) begin
            next_s.run = s.wdata[timer_capture_pkg::RUN_BIT_POS];
            next_s.clk_src = s.wdata[timer_capture_pkg::CLK_SRC_POS+:2];
            next_s.polarity = {s.wdata[timer_capture_pkg::EDGE_POLARITY_HIGH_POS],
                               s.wdata[timer_capture_pkg::EDGE_POLARITY_LOW_POS]};
            next_s.trig_src = s.wdata[timer_capture_pkg::TRIGGER_SOURCE_BIT_POS];
          end
        end
        timer_capture_pkg::CONTROL_REG_B_OFS: begin
          if (s.wstrb[0]) begin
            next_s.filt_rate = {s.wdata[timer_capture_pkg::FILTER_RATE_HIGH_POS],
                                s.wdata[timer_capture_pkg::FILTER_RATE_LOW_POS]};
            next_s.compare_mode = s.wdata[timer_capture_pkg::COMPARE_MODE_POS];
            next_s.pin_gpio = s.wdata[timer_capture_pkg::PIN_GPIO_POS];
          end
        end
        // Count is never written; capture only as compare value outside capture mode
        timer_capture_pkg::CAPTURE_REGISTER_OFS: begin
          if (wr_capture && !cap_event) begin
            next_s.capture = merge16(s.capture, s.wdata, s.wstrb);
          end
        end
        timer_capture_pkg::SECOND_COMPARE_OFS: begin
          next_s.compare1 = merge16(s.compare1, s.wdata, s.wstrb);
        end
        default: begin
        end
      endcase
    end
    if (awvalid && awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    // Read channel: one read in flight, data registered
    if (arvalid && arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_value;
      next_s.rresp = rd_hit ? timer_capture_pkg::RESP_OKAY : timer_capture_pkg::RESP_SLVERR;
    end else if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= timer_capture_pkg::TIMER_STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign awready = ~s.aw_got & ~s.bvalid;
  assign wready = ~s.w_got & ~s.bvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = ~s.rvalid;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign capture_pin_level = s.pin_sync;
  assign external_edge_irq = s.edge_irq;
  assign overflow_irq = s.ovf_irq;
  assign compare_irq = s.cmp_irq;
  // No waveform unit here: pins stay plain I/O unless compare mode lends them out
  assign wave_pins_claimed = s.compare_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  stop_clears_count_a: assert property (!s.run |=> s.count == 16'h0000)
    else $error("count not zero after stop");
  count_step_a: assert property (s.run && tick && s.count != 16'hffff |=> s.count == $past(s.count) + 16'h0001)
    else $error("count did not step on tick");
  count_hold_a: assert property (s.run && !tick && $past(s.run) |=> $stable(s.count))
    else $error("count moved without tick");
  capture_latch_a: assert property (cap_event |=> s.capture == $past(s.count))
    else $error("capture missed count");
  capture_hold_a: assert property (!cap_event && !wr_capture |=> $stable(s.capture))
    else $error("capture changed without edge");
  capture_no_write_a: assert property (do_write && !s.compare_mode && !cap_event |=> $stable(s.capture))
    else $error("capture written in capture mode");
  edge_irq_a: assert property (trig_edge |=> external_edge_irq ##1 !external_edge_irq || trig_edge)
    else $error("edge interrupt late or stuck");
  overflow_wrap_a: assert property (s.run && tick && s.count == 16'hffff |=> overflow_irq && s.count == 16'h0000)
    else $error("overflow not flagged on wrap");
  polarity_forbidden_a: assert property (s.polarity == 2'h3 |-> !trig_edge)
    else $error("forbidden polarity fired");
  gpio_pin_a: assert property (!s.trig_src && s.pin_gpio |-> !trig_edge)
    else $error("gpio pin triggered capture");
  compare_irq_a: assert property (compare_irq |-> s.compare_mode && (s.count == s.capture || s.count == s.compare1))
    else $error("compare interrupt without match");
  bvalid_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  // Read answers come one cycle after the taking edge, write answers one cycle after do_write; the slow trigger routes straight to the edge detector
  read_answer_a: assert property (arvalid && arready |=> rvalid && rdata == $past(rd_value))
    else $error("read answer late or wrong");
  write_answer_a: assert property (do_write |=> bvalid)
    else $error("write response missing");
  slow_trigger_a: assert property (s.trig_src && s.polarity == 2'h0 && s.slow_sync && !s.trig_prev |-> trig_edge)
    else $error("slow trigger edge lost");

  capture_seen_c: cover property (cap_event ##1 external_edge_irq);
  overflow_seen_c: cover property (overflow_irq);
  compare_seen_c: cover property (compare_irq);
  read_done_c: cover property (rvalid && rready && araddr == 6'h0c);
  slow_capture_c: cover property (s.trig_src && cap_event);

endmodule : timer_input_capture

// ===== pulse_source.sv
// Partner model: external measured pulse on the capture pin and the slow divided oscillator clock
`timescale 1ns/1ps
module pulse_source (
  input wire logic aclk,
  input wire logic fire,
  input wire logic [7:0] width,
  input wire logic slow_en,
  output logic pin,
  output logic slow_clk
);
  logic [7:0] left = 8'h00;
  logic [7:0] div = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse shaper: a fire request opens a high window of width clocks
  always @(posedge aclk) begin
    if (fire) begin
      left <= width;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign pin = (left != 8'h00);

  ////////////////////////////////////////////////////////////////////////////////
  // Slow clock restarts from low on enable, so the number of rising edges in a window is known
  always @(posedge aclk) begin
    div <= slow_en ? div + 8'h01 : 8'h00;
  end
  assign slow_clk = div[7]; // Period of 256 clocks, stands low while disabled
endmodule : pulse_source

// ===== tb.sv
// Testbench: register-level tests of the capture timer driven over AXI4-Lite
`timescale 1ns/1ps
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] awaddr = 6'h00;
  logic [5:0] araddr = 6'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic fast_clk = 1'b0;
  logic fire = 1'b0;
  logic [7:0] width = 8'h00;
  logic slow_en = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin, slow_clk, pin_d;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd, cap;
  logic pin_level, edge_irq, ovf_irq, cmp_irq, wave_claimed;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int edge_n = 0;
  int ovf_n = 0;
  int cmp_n = 0;
  int rise_at = 0;
  int irq_at = 0;
  int n0;
  int div;
  int k;

  always #50 aclk = ~aclk;
  // Fast oscillator at a fifth of the bus clock, phase offset so it never lines up with aclk
  initial begin
    #37;
    forever #250 fast_clk = ~fast_clk;
  end

  timer_input_capture i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .capture_input_pin(pin),
    .fast_osc_clock(fast_clk), .slow_osc_div_clock(slow_clk), .capture_pin_level(pin_level),
    .external_edge_irq(edge_irq), .overflow_irq(ovf_irq), .compare_irq(cmp_irq),
    .wave_pins_claimed(wave_claimed));

  pulse_source i_src (.aclk(aclk), .fire(fire), .width(width), .slow_en(slow_en), .pin(pin),
    .slow_clk(slow_clk));

  ////////////////////////////////////////////////////////////////////////////////
  // Event monitor and timeout: counts one-cycle pulses and the pin-to-irq moments
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    pin_d <= pin;
    if (pin === 1'b1 && pin_d === 1'b0) rise_at <= cyc;
    if (edge_irq === 1'b1) begin
      edge_n <= edge_n + 1;
      irq_at <= cyc;
    end
    if (ovf_irq === 1'b1) ovf_n <= ovf_n + 1;
    if (cmp_irq === 1'b1) cmp_n <= cmp_n + 1;
    if (cyc == 95000) begin
      fail_count++;
      results();
    end
  end

  task results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task check_rng(input string what, input int lo, input int hi, input logic [31:0] got);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("BAD %s expected %0d..%0d seen %h", what, lo, hi, got);
    end
  endtask : check_rng

  // Master waits on sampled handshakes only; valid drops at its own taking edge, ready stays high
  task axi_write(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    b_hs = 1'b0;
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = awvalid && (awready === 1'b1);
      w_hs = wvalid && (wready === 1'b1);
      b_hs = (bvalid === 1'b1);
      if (b_hs) r = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
  endtask : axi_write

  task axi_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs;
    logic r_hs;
    r_hs = 1'b0;
    r = 2'h3;
    d = 32'hdeadbeef;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = arvalid && (arready === 1'b1);
      r_hs = (rvalid === 1'b1);
      if (r_hs) d = rdata;
      if (r_hs) r = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
    end
  endtask : axi_read

  task wr(input logic [5:0] a, input logic [31:0] d);
    axi_write(a, d, rs);
    check("bresp", timer_capture_pkg::RESP_OKAY, {30'h0, rs});
  endtask : wr

  task rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp);
    axi_read(a, rd, rs); // Whole 32-bit word reads only
    check(what, exp, rd);
  endtask : rd_chk

  // Selections change only while stopped, then the run bit is set alone
  task start(input logic [7:0] cfg);
    wr(timer_capture_pkg::CONTROL_REG_A_OFS, {24'h0, cfg});
    wr(timer_capture_pkg::CONTROL_REG_A_OFS, {24'h0, cfg | 8'h01});
  endtask : start

  task pulse(input logic [7:0] w);
    width <= w;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (k = 0; k < 6; k++) rd_chk("reset value", 6'(k * 4), 32'h00000000);
    axi_read(6'h18, rd, rs);
    check("unmapped rresp", timer_capture_pkg::RESP_SLVERR, {30'h0, rs});
    axi_write(6'h1c, 32'h000000ff, rs);
    check("unmapped bresp", timer_capture_pkg::RESP_SLVERR, {30'h0, rs});
    // Every count source: rate over a 320 clock run, then zero after stop
    for (k = 0; k < 4; k++) begin
      div = (k == 0) ? 1 : (k == 1) ? 8 : (k == 2) ? 32 : 5;
      start(8'(k << timer_capture_pkg::CLK_SRC_POS));
      repeat (320) @(posedge aclk);
      axi_read(timer_capture_pkg::TIMER_COUNT_OFS, rd, rs);
      check_rng("count rate", 320 / div - 2, 320 / div + 8, rd);
      wr(timer_capture_pkg::CONTROL_REG_A_OFS, 32'h0);
      rd_chk("count after stop", timer_capture_pkg::TIMER_COUNT_OFS, 32'h0);
    end
    // Every polarity code on one high pulse: rising, falling, both, forbidden
    for (k = 0; k < 4; k++) begin
      start(8'(k << timer_capture_pkg::EDGE_POLARITY_LOW_POS));
      n0 = edge_n;
      repeat (40) @(posedge aclk);
      pulse(8'd20);
      repeat (60) @(posedge aclk);
      check("edge irq count", (k == 2) ? n0 + 2 : (k == 3) ? n0 : n0 + 1, edge_n);
      if (k == 0) begin
        check_rng("irq latency", 1, 6, irq_at - rise_at);
        axi_read(timer_capture_pkg::CAPTURE_REGISTER_OFS, cap, rs);
        check_rng("captured count", 40, 70, cap);
        rd_chk("capture held", timer_capture_pkg::CAPTURE_REGISTER_OFS, cap);
      end
      wr(timer_capture_pkg::CONTROL_REG_A_OFS, 32'h0);
    end
    // Capture mode ignores writes to count and capture; a slow running count shows a landed write
    start(8'(int'(timer_capture_pkg::SRC_DIV32) << timer_capture_pkg::CLK_SRC_POS));
    axi_read(timer_capture_pkg::CAPTURE_REGISTER_OFS, cap, rs);
    wr(timer_capture_pkg::TIMER_COUNT_OFS, 32'h00001234);
    wr(timer_capture_pkg::CAPTURE_REGISTER_OFS, 32'h00001234);
    axi_read(timer_capture_pkg::TIMER_COUNT_OFS, rd, rs);
    check_rng("count write ignored", 0, 8, rd);
    rd_chk("capture write ignored", timer_capture_pkg::CAPTURE_REGISTER_OFS, cap);
    wr(timer_capture_pkg::CONTROL_REG_A_OFS, 32'h0);
    // Filter rates: a one clock glitch is rejected, a long pulse is taken
    for (k = 1; k < 4; k++) begin
      wr(timer_capture_pkg::CONTROL_REG_B_OFS, 32'(k));
      start(8'h00);
      n0 = edge_n;
      pulse(8'd1);
      repeat (120) @(posedge aclk);
      check("glitch rejected", n0, edge_n);
      pulse(8'd200);
      repeat (300) @(posedge aclk);
      check("filtered edge", n0 + 1, edge_n);
      wr(timer_capture_pkg::CONTROL_REG_A_OFS, 32'h0);
    end
    // Pin as general purpose input: level visible, no trigger, waveform pins free
    wr(timer_capture_pkg::CONTROL_REG_B_OFS, 32'h1 << timer_capture_pkg::PIN_GPIO_POS);
    start(8'h00);
    n0 = edge_n;
    pulse(8'd40);
    repeat (10) @(posedge aclk);
    check("pin level", 32'h1, {31'h0, pin_level});
    repeat (60) @(posedge aclk);
    check("gpio no trigger", n0, edge_n);
    check("wave pins in capture", 32'h0, {31'h0, wave_claimed});
    wr(timer_capture_pkg::CONTROL_REG_A_OFS, 32'h0);
    // Slow oscillator trigger: two rising edges in a 600 clock window
    wr(timer_capture_pkg::CONTROL_REG_B_OFS, 32'h0);
    start(8'h1 << timer_capture_pkg::TRIGGER_SOURCE_BIT_POS);
    n0 = edge_n;
    slow_en <= 1'b1;
    repeat (600) @(posedge aclk);
    slow_en <= 1'b0;
    check("slow trigger edges", n0 + 2, edge_n);
    wr(timer_capture_pkg::CONTROL_REG_A_OFS, 32'h0);
    // Compare mode: both compare registers match once each
    wr(timer_capture_pkg::CONTROL_REG_B_OFS, 32'h1 << timer_capture_pkg::COMPARE_MODE_POS);
    wr(timer_capture_pkg::CAPTURE_REGISTER_OFS, 32'h00000040);
    wr(timer_capture_pkg::SECOND_COMPARE_OFS, 32'h00000080);
    n0 = cmp_n;
    start(8'h00);
    repeat (200) @(posedge aclk);
    check("compare matches", n0 + 2, cmp_n);
    check("wave pins in compare", 32'h1, {31'h0, wave_claimed});
    wr(timer_capture_pkg::CONTROL_REG_A_OFS, 32'h0);
    wr(timer_capture_pkg::CONTROL_REG_B_OFS, 32'h0);
    // Overflow: one wrap in a full undivided lap
    n0 = ovf_n;
    start(8'h00);
    repeat (65600) @(posedge aclk);
    check("overflow count", n0 + 1, ovf_n);
    wr(timer_capture_pkg::CONTROL_REG_A_OFS, 32'h0);
    results();
  end
endmodule : tb
